/* File: inc/bst_pkg.sv */
package bst_pkg;

    // ************************************************************
    // Instruction codes and widths
    // ************************************************************
    localparam int         IR_W          = 4;
    localparam logic [3:0] INS_EXTEST    = 4'h0;
    localparam logic [3:0] INS_IDCODE    = 4'h1;
    localparam logic [3:0] INS_SAMPLE    = 4'h2;
    localparam logic [3:0] INS_CPU_RESET = 4'hC;
    localparam logic [3:0] INS_BYPASS    = 4'hF;
    localparam logic [3:0] IR_CAPTURE    = 4'h1;
    localparam int         ID_W          = 32;

    // ************************************************************
    // I/O register map and fields
    // ************************************************************
    localparam logic [5:0] ADDR_STATUS   = 6'h34;
    localparam logic [5:0] ADDR_CONTROL  = 6'h35;
    localparam int         BIT_DISABLE   = 7;
    localparam int         BIT_PUD       = 4;
    localparam int         BIT_TRF       = 4;
    localparam logic [7:0] CONTROL_RST   = 8'h00;
    localparam logic [7:0] STATUS_RST    = 8'h00;
    localparam logic [7:0] CONTROL_RWMSK = 8'h93;
    localparam logic [7:0] STATUS_RWMSK  = 8'h1F;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam logic [2:0] DIS_WINDOW    = 3'h4;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [3:0] {
        ST_RESET   = 4'b0000,
        ST_IDLE    = 4'b0001,
        ST_SEL_DR  = 4'b0010,
        ST_CAP_DR  = 4'b0011,
        ST_SH_DR   = 4'b0100,
        ST_EX1_DR  = 4'b0101,
        ST_PAU_DR  = 4'b0110,
        ST_EX2_DR  = 4'b0111,
        ST_UPD_DR  = 4'b1000,
        ST_SEL_IR  = 4'b1001,
        ST_CAP_IR  = 4'b1010,
        ST_SH_IR   = 4'b1011,
        ST_EX1_IR  = 4'b1100,
        ST_PAU_IR  = 4'b1101,
        ST_EX2_IR  = 4'b1110,
        ST_UPD_IR  = 4'b1111
    } bst_state_e;

    // Update latches of one pin cell
    typedef struct packed {
        logic ctl;
        logic dat;
    } bst_cell_s;

    // I/O register access from the CPU
    typedef struct packed {
        logic [5:0] addr;
        logic       wr;
        logic [7:0] wdata;
    } bst_io_s;

endpackage

/* File: src/bst_pin_cell.sv */
`timescale 1ns/1ns

// ************************************************************
// Bidirectional pin cell: output muxing and pull-up
// ************************************************************
module bst_pin_cell (
    input  wire logic              i_extest,
    input  wire logic              i_scan_mode,
    input  wire bst_pkg::bst_cell_s i_latch,
    input  wire logic              i_port_output_bit,
    input  wire logic              i_direction_bit,
    input  wire logic              i_global_pullup_disable,
    input  wire logic              i_clk_route,
    input  wire logic              i_clk_level,
    input  wire logic              i_pin,
    output logic                   o_pin_out,
    output logic                   o_pin_oe,
    output logic                   o_pin_pullup_enable,
    output logic                   o_pin_input_data
);

    // Latches reach the pin only under EXTEST; preload stays internal
    always_comb begin
        if (i_extest) begin
            o_pin_out = i_latch.dat;
            o_pin_oe  = i_latch.ctl;
        end else if (i_clk_route && !i_scan_mode) begin
            o_pin_out = i_clk_level;
            o_pin_oe  = 1'b1;
        end else begin
            o_pin_out = i_port_output_bit;
            o_pin_oe  = i_direction_bit;
        end
    end

    // Pull-up off in scan modes, else the usual port expression
    assign o_pin_pullup_enable = !i_scan_mode && !i_global_pullup_disable
                                 && !i_direction_bit && i_port_output_bit;
    // Raw pin level, deliberately without a synchroniser
    assign o_pin_input_data    = i_pin;

endmodule

/* File: src/bst_tap.sv */
`timescale 1ns/1ns

module bst_tap #(
    parameter int          NUM_PINS    = 8,
    parameter int          RST_TIMEOUT = 16,
    parameter logic [3:0]  ID_VERSION  = 4'h0,
    parameter logic [15:0] ID_PART     = 16'h1234, // Arbitrary value
    parameter logic [10:0] ID_MAKER    = 11'h055   // Arbitrary value
) (
    input  wire logic                 i_clk,
    input  wire logic                 i_rstn,
    input  wire logic                 i_ce,
    input  wire logic                 i_tck,
    input  wire logic                 i_tms,
    input  wire logic                 i_tdi,
    output logic                      o_tdo,
    output logic                      o_tdo_oe,
    input  wire logic                 i_test_port_enable_fuse,
    input  wire logic                 i_clock_output_fuse,
    input  wire logic                 i_clk_level,
    input  wire logic                 i_ext_reset_n,
    input  wire bst_pkg::bst_io_s     i_io,
    output logic [7:0]                o_io_rdata,
    input  wire logic [NUM_PINS-1:0]  i_port_output_bit,
    input  wire logic [NUM_PINS-1:0]  i_direction_bit,
    input  wire logic [NUM_PINS-1:0]  i_pin,
    output logic [NUM_PINS-1:0]       o_pin_out,
    output logic [NUM_PINS-1:0]       o_pin_oe,
    output logic [NUM_PINS-1:0]       o_pin_pullup_enable,
    output logic [NUM_PINS-1:0]       o_pin_input_data,
    output logic                      o_cpu_reset
);

    localparam int CHAIN_W = 2 * NUM_PINS + 1;
    localparam int DR_W    = (CHAIN_W > bst_pkg::ID_W) ? CHAIN_W : bst_pkg::ID_W;
    localparam int TO_W    = $clog2(RST_TIMEOUT + 1);

    // ************************************************************
    // Parameter checks
    // ************************************************************
    if (NUM_PINS < 1 || NUM_PINS > 64) begin : g_chk_pins
        $error("NUM_PINS out of range");
    end
    if (RST_TIMEOUT < 1) begin : g_chk_to
        $error("RST_TIMEOUT must be at least one");
    end

    // Serial length of the selected data path
    function automatic int dr_len(input logic [3:0] ins);
        if (ins == bst_pkg::INS_EXTEST || ins == bst_pkg::INS_SAMPLE) begin
            dr_len = CHAIN_W;
        end else if (ins == bst_pkg::INS_IDCODE) begin
            dr_len = bst_pkg::ID_W;
        end else begin
            dr_len = 1;
        end
    endfunction

    // ************************************************************
    // Reset release and pin synchronisers
    // ************************************************************
    logic       rst_meta;
    logic       rst_n;
    logic [2:0] pin_meta;
    logic [2:0] pin_sync;
    logic       tck_prev;

    // Async assert, clocked release
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // TCK, TMS, TDI come from the tester's domain
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta <= 3'h0;
            pin_sync <= 3'h0;
            tck_prev <= 1'b0;
        end else if (i_ce) begin
            pin_meta <= {i_tck, i_tms, i_tdi};
            pin_sync <= pin_meta;
            tck_prev <= pin_sync[2];
        end
    end

    logic tck_rise;
    logic tck_fall;
    logic tms;
    logic tdi;
    logic port_on;
    assign tck_rise = pin_sync[2] && !tck_prev;
    assign tck_fall = !pin_sync[2] && tck_prev;
    assign tms      = pin_sync[1];
    assign tdi      = pin_sync[0];

    // ************************************************************
    // TAP state machine
    // ************************************************************
    bst_pkg::bst_state_e state;
    bst_pkg::bst_state_e next_state;

    // Standard diagram, advanced on TCK rising edges; forced to reset at once while the port is off
    always_comb begin
        next_state = state;
        if (!port_on) begin
            next_state = bst_pkg::ST_RESET;
        end else if (tck_rise) begin
            case (state)
                bst_pkg::ST_RESET:  next_state = tms ? bst_pkg::ST_RESET  : bst_pkg::ST_IDLE;
                bst_pkg::ST_IDLE:   next_state = tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
                bst_pkg::ST_SEL_DR: next_state = tms ? bst_pkg::ST_SEL_IR : bst_pkg::ST_CAP_DR;
                bst_pkg::ST_CAP_DR: next_state = tms ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
                bst_pkg::ST_SH_DR:  next_state = tms ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
                bst_pkg::ST_EX1_DR: next_state = tms ? bst_pkg::ST_UPD_DR : bst_pkg::ST_PAU_DR;
                bst_pkg::ST_PAU_DR: next_state = tms ? bst_pkg::ST_EX2_DR : bst_pkg::ST_PAU_DR;
                bst_pkg::ST_EX2_DR: next_state = tms ? bst_pkg::ST_UPD_DR : bst_pkg::ST_SH_DR;
                bst_pkg::ST_UPD_DR: next_state = tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
                bst_pkg::ST_SEL_IR: next_state = tms ? bst_pkg::ST_RESET  : bst_pkg::ST_CAP_IR;
                bst_pkg::ST_CAP_IR: next_state = tms ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
                bst_pkg::ST_SH_IR:  next_state = tms ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
                bst_pkg::ST_EX1_IR: next_state = tms ? bst_pkg::ST_UPD_IR : bst_pkg::ST_PAU_IR;
                bst_pkg::ST_PAU_IR: next_state = tms ? bst_pkg::ST_EX2_IR : bst_pkg::ST_PAU_IR;
                bst_pkg::ST_EX2_IR: next_state = tms ? bst_pkg::ST_UPD_IR : bst_pkg::ST_SH_IR;
                default:            next_state = tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= bst_pkg::ST_RESET;
        end else if (i_ce) begin
            state <= next_state;
        end
    end

    // ************************************************************
    // Instruction and data shift paths
    // ************************************************************
    logic [3:0]          ir_sh;
    logic [3:0]          ir;
    logic [DR_W-1:0]     dr;
    logic                rst_bit;
    bst_pkg::bst_cell_s  latch [NUM_PINS];
    logic [3:0]          next_ir_sh;
    logic [3:0]          next_ir;
    logic [DR_W-1:0]     next_dr;
    logic                next_rst_bit;
    bst_pkg::bst_cell_s  next_latch [NUM_PINS];
    logic                scan_mode;
    logic                extest;
    logic [NUM_PINS-1:0] pin_in;

    assign extest    = (ir == bst_pkg::INS_EXTEST);
    assign scan_mode = extest || (ir == bst_pkg::INS_SAMPLE);

    // Capture, shift and update on TCK rising edges
    always_comb begin
        int len;
        len          = dr_len(ir);
        next_ir_sh   = ir_sh;
        next_ir      = ir;
        next_dr      = dr;
        next_rst_bit = rst_bit;
        next_latch   = latch;
        if (state == bst_pkg::ST_RESET) begin
            next_ir = bst_pkg::INS_IDCODE;
        end
        if (tck_rise && port_on) begin
            case (state)
                bst_pkg::ST_CAP_IR: next_ir_sh = bst_pkg::IR_CAPTURE;
                bst_pkg::ST_SH_IR:  next_ir_sh = {tdi, ir_sh[3:1]};
                bst_pkg::ST_UPD_IR: next_ir    = ir_sh;
                bst_pkg::ST_CAP_DR: begin
                    next_dr = '0;
                    if (ir == bst_pkg::INS_IDCODE) begin
                        next_dr[bst_pkg::ID_W-1:0] = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
                    end else if (scan_mode) begin
                        for (int i = 0; i < NUM_PINS; i++) begin
                            next_dr[2*i]   = o_pin_oe[i];
                            next_dr[2*i+1] = pin_in[i];
                        end
                        next_dr[CHAIN_W-1] = i_ext_reset_n;
                    end
                end
                bst_pkg::ST_SH_DR: begin
                    if (ir == bst_pkg::INS_CPU_RESET) begin
                        next_rst_bit = tdi;
                    end else begin
                        next_dr          = dr >> 1;
                        next_dr[len - 1] = tdi;
                    end
                end
                bst_pkg::ST_UPD_DR: begin
                    if (scan_mode) begin
                        for (int i = 0; i < NUM_PINS; i++) begin
                            next_latch[i].ctl = dr[2*i];
                            next_latch[i].dat = dr[2*i+1];
                        end
                    end
                end
                default: next_ir_sh = ir_sh;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            ir_sh   <= bst_pkg::IR_CAPTURE;
            ir      <= bst_pkg::INS_IDCODE;
            dr      <= '0;
            rst_bit <= 1'b0;
            for (int i = 0; i < NUM_PINS; i++) begin
                latch[i] <= '0;
            end
        end else if (i_ce) begin
            ir_sh   <= next_ir_sh;
            ir      <= next_ir;
            dr      <= next_dr;
            rst_bit <= next_rst_bit;
            latch   <= next_latch;
        end
    end

    // ************************************************************
    // Serial output, changed on TCK falling edges; enable cleared at once while the port is off
    // ************************************************************
    logic next_tdo;
    logic next_tdo_oe;

    always_comb begin
        next_tdo    = o_tdo;
        next_tdo_oe = o_tdo_oe;
        if (!port_on) begin
            next_tdo_oe = 1'b0;
        end else if (tck_fall) begin
            next_tdo_oe = (state == bst_pkg::ST_SH_DR) || (state == bst_pkg::ST_SH_IR);
            if (state == bst_pkg::ST_SH_IR) begin
                next_tdo = ir_sh[0];
            end else if (ir == bst_pkg::INS_CPU_RESET) begin
                next_tdo = rst_bit;
            end else begin
                next_tdo = dr[0];
            end
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_tdo    <= 1'b0;
            o_tdo_oe <= 1'b0;
        end else if (i_ce) begin
            o_tdo    <= next_tdo;
            o_tdo_oe <= next_tdo_oe;
        end
    end

    // ************************************************************
    // Control and status registers, CPU reset
    // ************************************************************
    logic [7:0]      ctrl;
    logic [7:0]      stat;
    logic [2:0]      dis_cnt;
    logic            dis_val;
    logic [TO_W-1:0] to_cnt;
    logic [7:0]      next_ctrl;
    logic [7:0]      next_stat;
    logic [2:0]      next_dis_cnt;
    logic            next_dis_val;
    logic [TO_W-1:0] next_to_cnt;
    logic            wr_ctrl;
    logic            wr_stat;
    logic            test_port_disable;

    assign test_port_disable = ctrl[bst_pkg::BIT_DISABLE];
    assign port_on           = i_test_port_enable_fuse && !test_port_disable;

    // Address decode of the I/O port
    always_comb begin
        wr_ctrl    = 1'b0;
        wr_stat    = 1'b0;
        o_io_rdata = 8'h00;
        if (i_io.addr == bst_pkg::ADDR_CONTROL) begin
            wr_ctrl    = i_io.wr;
            o_io_rdata = ctrl;
        end else if (i_io.addr == bst_pkg::ADDR_STATUS) begin
            wr_stat    = i_io.wr;
            o_io_rdata = stat;
        end
    end

    // Disable bit moves only on a matching second write in the window
    always_comb begin
        next_ctrl    = ctrl;
        next_dis_cnt = (dis_cnt != 3'h0) ? dis_cnt - 3'h1 : 3'h0;
        next_dis_val = dis_val;
        if (wr_ctrl) begin
            next_ctrl = (i_io.wdata & bst_pkg::CONTROL_RWMSK & ~(8'h01 << bst_pkg::BIT_DISABLE))
                        | (ctrl & (8'h01 << bst_pkg::BIT_DISABLE));
            if (dis_cnt != 3'h0 && i_io.wdata[bst_pkg::BIT_DISABLE] == dis_val) begin
                next_ctrl[bst_pkg::BIT_DISABLE] = dis_val;
                next_dis_cnt = 3'h0;
            end else begin
                next_dis_val = i_io.wdata[bst_pkg::BIT_DISABLE];
                next_dis_cnt = bst_pkg::DIS_WINDOW - 3'h1;
            end
        end
    end

    // Flag set by the test reset wins over a software clear
    always_comb begin
        next_stat = stat;
        if (wr_stat) begin
            next_stat = i_io.wdata & bst_pkg::STATUS_RWMSK;
        end
        if (rst_bit) begin
            next_stat[bst_pkg::BIT_TRF] = 1'b1;
        end
    end

    // Time-out restarts each cycle the reset bit is high
    always_comb begin
        if (rst_bit) begin
            next_to_cnt = TO_W'(RST_TIMEOUT);
        end else if (to_cnt != '0) begin
            next_to_cnt = to_cnt - 1'b1;
        end else begin
            next_to_cnt = to_cnt;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl    <= bst_pkg::CONTROL_RST;
            stat    <= bst_pkg::STATUS_RST;
            dis_cnt <= 3'h0;
            dis_val <= 1'b0;
            to_cnt  <= '0;
        end else if (i_ce) begin
            ctrl    <= next_ctrl;
            stat    <= next_stat;
            dis_cnt <= next_dis_cnt;
            dis_val <= next_dis_val;
            to_cnt  <= next_to_cnt;
        end
    end

    // Unlatched: reset rises as the bit shifts in and is held RST_TIMEOUT cycles after it clears; no HIGHZ needed
    assign o_cpu_reset = rst_bit || (to_cnt != '0);

    // ************************************************************
    // Pin cells
    // ************************************************************
    for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
        bst_pin_cell u_cell (
            .i_extest                (extest),
            .i_scan_mode             (scan_mode),
            .i_latch                 (latch[g]),
            .i_port_output_bit       (i_port_output_bit[g]),
            .i_direction_bit         (i_direction_bit[g]),
            .i_global_pullup_disable (ctrl[bst_pkg::BIT_PUD]),
            .i_clk_route             (i_clock_output_fuse && (g == 0)),
            .i_clk_level             (i_clk_level),
            .i_pin                   (i_pin[g]),
            .o_pin_out               (o_pin_out[g]),
            .o_pin_oe                (o_pin_oe[g]),
            .o_pin_pullup_enable     (o_pin_pullup_enable[g]),
            .o_pin_input_data        (pin_in[g])
        );
    end
    assign o_pin_input_data = pin_in;

endmodule

/* File: bench/bst_tap_monitor.sv */
`timescale 1ns/1ns
// Port-level watcher of the tap block
module bst_tap_monitor #(
    parameter int NUM_PINS    = 8,
    parameter int RST_TIMEOUT = 16
) (
    input wire logic                i_clk,
    input wire logic                i_rstn,
    input wire logic                i_tck,
    input wire logic                o_tdo,
    input wire logic                o_tdo_oe,
    input wire bst_pkg::bst_io_s    i_io,
    input wire logic [7:0]          o_io_rdata,
    input wire logic [NUM_PINS-1:0] i_port_output_bit,
    input wire logic [NUM_PINS-1:0] i_direction_bit,
    input wire logic [NUM_PINS-1:0] i_pin,
    input wire logic [NUM_PINS-1:0] o_pin_pullup_enable,
    input wire logic [NUM_PINS-1:0] o_pin_input_data,
    input wire logic                o_cpu_reset
);
    // ****************************************
    // One clock domain, so one default
    // ****************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    a_raw_pin_in: assert property (o_pin_input_data == i_pin)
        else $error("pin input not raw");
    a_pullup_gate: assert property
        ((o_pin_pullup_enable & (i_direction_bit | ~i_port_output_bit)) == '0) else $error("bad pull-up");
    a_ctrl_reserved: assert property
        ((i_io.addr == bst_pkg::ADDR_CONTROL) |-> (o_io_rdata & ~bst_pkg::CONTROL_RWMSK) == 8'h00)
        else $error("control reserved bits set");
    a_status_reserved: assert property
        ((i_io.addr == bst_pkg::ADDR_STATUS) |-> o_io_rdata[7:5] == 3'h0) else $error("status reserved set");
    a_flag_on_reset: assert property
        ($rose(o_cpu_reset) ##2 (i_io.addr == bst_pkg::ADDR_STATUS) |-> o_io_rdata[4])
        else $error("reset flag not set");
    a_reset_timeout: assert property ($fell(o_cpu_reset) |-> $past(o_cpu_reset, RST_TIMEOUT))
        else $error("cpu reset released early");
    a_port_off_quiet: assert property
        ((i_io.addr == bst_pkg::ADDR_CONTROL && o_io_rdata[7]) |=> !o_tdo_oe) else $error("tdo on while off");
    a_tdo_on_fall: assert property ($changed(o_tdo) |-> !$past(i_tck, 2) || !$past(i_tck, 3))
        else $error("tdo moved off a falling edge");
    c_shift: cover property ($rose(o_tdo_oe));
    c_cpu_release: cover property ($fell(o_cpu_reset));
    c_flag: cover property ($rose(o_io_rdata[4]));
endmodule

/* File: bench/bst_jtag_host.sv */
`timescale 1ns/1ns
// Test controller: one step is a whole test clock period
module bst_jtag_host (
    input  wire logic i_clk,
    input  wire logic i_tdo,
    output logic      o_tck,
    output logic      o_tms,
    output logic      o_tdi
);
    // ****************************************
    // Bit and scan tasks
    // ****************************************
    initial begin
        o_tck = 1'b0;
        o_tms = 1'b1;
        o_tdi = 1'b1;
    end
    // Low and high phases of four clocks each, tdo taken late in high
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        @(posedge i_clk);
        o_tck <= 1'b0;
        o_tms <= tms;
        o_tdi <= tdi;
        repeat (4) @(posedge i_clk);
        o_tck <= 1'b1;
        repeat (3) @(posedge i_clk);
        @(negedge i_clk);
        tdo = i_tdo;
    endtask
    // Five ones reach reset from anywhere, then idle
    task automatic tlr;
        logic b;
        repeat (5) step(1'b1, 1'b1, b);
        step(1'b0, 1'b1, b);
    endtask
    // From idle through capture, shift, update and back to idle
    task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
        logic b;
        dout = '0;
        step(1'b1, 1'b1, b);
        if (ir) step(1'b1, 1'b1, b);
        step(1'b0, 1'b1, b);
        step(1'b0, 1'b1, b);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], b);
            dout[i] = b;
        end
        step(1'b1, 1'b1, b);
        step(1'b0, 1'b1, b);
    endtask
endmodule

/* File: bench/testbench.sv */
`timescale 1ns/1ns
module testbench;
    typedef struct packed {
        logic [3:0]  ins;
        logic [5:0]  n;
        logic [31:0] din;
        logic [31:0] exp;
        logic [31:0] msk;
    } bst_row_s;
    // Identity fields are arbitrary
    localparam logic [31:0] ID = {4'h3, 16'hA5C3, 11'h2B1, 1'b1};
    logic                i_clk = 1'b0;
    logic                i_rstn = 1'b0;
    logic                ce = 1'h1, fuse = 1'h1, clock_output_fuse = 1'h0;
    logic                tck, tms, tdi, tdo, tdo_oe, ext_n, cpu_rst;
    bst_pkg::bst_io_s    io;
    logic [7:0]          rdata, port, dir, pin, pin_out, pin_oe, pu;
    logic [31:0]         d;
    int                  num_errors = 0;
    int                  comparisons = 0;
    // Chain image: control even, data odd, reset pin on top
    function automatic logic [31:0] chain(input logic [7:0] c, input logic [7:0] v, input logic r);
        logic [31:0] x;
        x = '0;
        x[16] = r;
        for (int i = 0; i < 8; i++) begin
            x[2*i] = c[i];
            x[2*i+1] = v[i];
        end
        return x;
    endfunction
    localparam bst_row_s ROWS [4] = '{
        '{bst_pkg::INS_IDCODE, 6'd32, 32'h0, ID, 32'hFFFFFFFF},
        '{bst_pkg::INS_BYPASS, 6'd2, 32'h3, 32'h2, 32'h3},
        '{4'h5, 6'd2, 32'h3, 32'h2, 32'h3},
        '{bst_pkg::INS_SAMPLE, 6'd17, 32'h0, chain(8'h00, 8'hA5, 1'b1), 32'h1AAAA}};
    always #25 i_clk = ~i_clk;
    bst_tap #(.RST_TIMEOUT(4), .ID_VERSION(4'h3), .ID_PART(16'hA5C3), .ID_MAKER(11'h2B1)) u_bst_tap (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_ce(ce), .i_tck(tck), .i_tms(tms), .i_tdi(tdi), .o_tdo(tdo),
        .o_tdo_oe(tdo_oe), .i_test_port_enable_fuse(fuse), .i_clock_output_fuse(clock_output_fuse), .i_clk_level(1'b0),
        .i_ext_reset_n(ext_n), .i_io(io), .o_io_rdata(rdata), .i_port_output_bit(port), .i_direction_bit(dir),
        .i_pin(pin), .o_pin_out(pin_out), .o_pin_oe(pin_oe), .o_pin_pullup_enable(pu), .o_pin_input_data(),
        .o_cpu_reset(cpu_rst));
    bst_jtag_host u_bst_jtag_host (.i_clk(i_clk), .i_tdo(tdo), .o_tck(tck), .o_tms(tms), .o_tdi(tdi));
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask
    // One-cycle write strobe
    task automatic wr(input logic [5:0] a, input logic [7:0] v);
        @(posedge i_clk);
        io <= '{a, 1'b1, v};
        @(posedge i_clk);
        io.wr <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] e, input string m);
        @(posedge i_clk);
        io.addr <= a;
        @(negedge i_clk);
        check(32'(rdata), 32'(e), m);
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Whole sequence needs about a tenth of a millisecond
    initial begin
        #3000000;
        num_errors++;
        stop_test();
    end
    initial begin
        io = '0;
        port = 8'hF0;
        dir = 8'h0F;
        pin = 8'hA5;
        ext_n = 1'b1;
        repeat (20) @(posedge i_clk);
        i_rstn <= 1'b1;
        repeat (4) @(posedge i_clk);
        rd(bst_pkg::ADDR_CONTROL, bst_pkg::CONTROL_RST, "control reset");
        rd(bst_pkg::ADDR_STATUS, bst_pkg::STATUS_RST, "status reset");
        rd(6'h20, 8'h00, "unmapped read");
        u_bst_jtag_host.tlr();
        u_bst_jtag_host.scan(1'b0, 32, 32'h0, d);
        check(d, ID, "default path");
        $display("reset test done");
        foreach (ROWS[k]) begin
            u_bst_jtag_host.scan(1'b1, 4, 32'(ROWS[k].ins), d);
            check(d, 32'(bst_pkg::IR_CAPTURE), "ir capture");
            u_bst_jtag_host.scan(1'b0, int'(ROWS[k].n), ROWS[k].din, d);
            check(d & ROWS[k].msk, ROWS[k].exp, "row data");
            $display("row %0d done", k);
        end
        // Preload safe values, then drive them
        u_bst_jtag_host.scan(1'b0, 17, chain(8'hFF, 8'h3C, 1'b0), d);
        check({pin_oe, pin_out, pu}, {dir, port, 8'h00}, "preload touched pins");
        u_bst_jtag_host.scan(1'b1, 4, 32'(bst_pkg::INS_EXTEST), d);
        check({pin_oe, pin_out}, 16'hFF3C, "extest drive");
        u_bst_jtag_host.scan(1'b0, 17, chain(8'h0F, 8'hC3, 1'b0), d);
        check(d & 32'h1AAAA, chain(8'h00, pin, 1'b1), "extest capture");
        check({pin_oe, pin_out, pu}, 24'h0FC300, "extest update");
        u_bst_jtag_host.scan(1'b1, 4, 32'(bst_pkg::INS_BYPASS), d);
        check(32'(pu), 32'hF0, "pull-up map");
        $display("scan test done");
        // Status stays addressed so the flag is seen
        @(posedge i_clk);
        io.addr <= bst_pkg::ADDR_STATUS;
        u_bst_jtag_host.scan(1'b1, 4, 32'(bst_pkg::INS_CPU_RESET), d);
        u_bst_jtag_host.scan(1'b0, 1, 32'h1, d);
        check({d[29:0], cpu_rst, rdata[4]}, 32'h3, "cpu reset on");
        u_bst_jtag_host.scan(1'b0, 1, 32'h0, d);
        check({d[30:0], cpu_rst}, 32'h2, "cpu reset off");
        wr(bst_pkg::ADDR_STATUS, 8'h00);
        rd(bst_pkg::ADDR_STATUS, 8'h00, "flag clear");
        wr(bst_pkg::ADDR_CONTROL, 8'h80);
        repeat (6) @(posedge i_clk);
        rd(bst_pkg::ADDR_CONTROL, 8'h00, "single write");
        wr(bst_pkg::ADDR_CONTROL, 8'h80);
        wr(bst_pkg::ADDR_CONTROL, 8'h80);
        rd(bst_pkg::ADDR_CONTROL, 8'h80, "double write");
        u_bst_jtag_host.scan(1'b0, 4, 32'h0, d);
        $display("register test done");
        stop_test();
    end
endmodule
bind bst_tap bst_tap_monitor #(.NUM_PINS(NUM_PINS), .RST_TIMEOUT(RST_TIMEOUT)) u_bst_tap_monitor (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_tck(i_tck), .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe), .i_io(i_io),
    .o_io_rdata(o_io_rdata), .i_port_output_bit(i_port_output_bit), .i_direction_bit(i_direction_bit),
    .i_pin(i_pin), .o_pin_pullup_enable(o_pin_pullup_enable), .o_pin_input_data(o_pin_input_data),
    .o_cpu_reset(o_cpu_reset));
